// ### verilog/tcc_timer.sv
// Timer channels with bus access contention handling behind an APB slave.
`timescale 1ns/10ps
`default_nettype none
module tcc_timer
    import tcc_pkg::*;
#(
    parameter int NCH = NCH_DEF
) (
    input wire logic CLOCK,
    input wire logic RESET_N,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic [NCH-1:0] CAPTURE_A,
    input wire logic [NCH-1:0] CAPTURE_B,
    output logic [1:0] COMBINED_MODE,
    output logic IRQ
);
    localparam int IW = NCH * NFLAG;

    typedef struct packed {
        tcc_phase_t phase;
        logic [NCH-1:0][15:0] cnt;
        logic [NCH-1:0][15:0] gra;
        logic [NCH-1:0][15:0] grb;
        logic [NCH-1:0][15:0] bra;
        logic [NCH-1:0][CTL_W-1:0] ctl;
        logic [NCH-1:0][NFLAG-1:0] flag;
        logic [NCH-1:0][NFLAG-1:0] armed;
        logic [NCH-1:0] sync;
        logic [1:0] fmode;
        logic [IW-1:0] ist;
        logic [IW-1:0] ien;
        logic [31:0] rdata;
        logic slverr;
    } tcc_state_t;

    tcc_state_t s;
    tcc_state_t n;
    logic [NRATE-1:0] tick;
    logic [NCH-1:0] inc, wrap, cmp_a, cmp_b, cap_a, cap_b;
    logic [NCH-1:0] own_clr, clr, cwr, bhold, gra_wr, grb_wr;
    logic [NCH-1:0][15:0] cval;
    logic acc, commit, wr_now;

    // Address of a channel register.
    function automatic logic ch_hit(input logic [7:0] a, input int ch,
                                    input logic [7:0] ofs);
        logic [7:0] base;
        base = 8'(ch) * CH_STRIDE;
        return a == (base + ofs);
    endfunction : ch_hit

    tcc_prescale #(
        .NR(NRATE)
    ) u_prescale (
        .CLOCK(CLOCK),
        .RESET_N(RESET_N),
        .TICK(tick)
    );

    // Next state of the bus engine, counters, registers and flags.
    always_comb begin
        logic [15:0] full;
        logic hit;
        logic is_byte;
        logic [NFLAG-1:0] evts;
        logic [NFLAG-1:0] fclr;
        logic [IW-1:0] ev_all;
        logic [2:0] ch;
        logic [31:0] rd;
        logic ok;
        full = '0;
        hit = 1'b0;
        is_byte = 1'b0;
        evts = '0;
        fclr = '0;
        ev_all = '0;
        ch = PADDR[7:5];
        rd = '0;
        ok = 1'b0;
        n = s;
        inc = '0;
        wrap = '0;
        cmp_a = '0;
        cmp_b = '0;
        cap_a = '0;
        cap_b = '0;
        own_clr = '0;
        clr = '0;
        cwr = '0;
        bhold = '0;
        gra_wr = '0;
        grb_wr = '0;
        cval = '0;
        acc = PSEL && PENABLE;
        commit = acc && (s.phase == PH_T3);
        wr_now = commit && PWRITE;
        // Each access runs setup, second and third state; it ends in the third.
        case (s.phase)
            PH_IDLE: begin
                if (PSEL && !PENABLE) begin
                    n.phase = PH_T2;
                end
            end
            PH_T2: n.phase = PH_T3;
            PH_T3: n.phase = PH_IDLE;
            default: n.phase = PH_IDLE;
        endcase
        // Counter writes pick the word or a half by address and fan out to synced peers.
        for (int k = 0; k < NCH; k++) begin
            hit = 1'b0;
            is_byte = 1'b0;
            full = s.cnt[k];
            if (ch_hit(PADDR, k, OFS_CNT)) begin
                hit = 1'b1;
                full = PWDATA[15:0];
            end
            if (ch_hit(PADDR, k, OFS_CNT_HI)) begin
                hit = 1'b1;
                is_byte = 1'b1;
                full = {PWDATA[7:0], s.cnt[k][7:0]};
            end
            if (ch_hit(PADDR, k, OFS_CNT_LO)) begin
                hit = 1'b1;
                is_byte = 1'b1;
                full = {s.cnt[k][15:8], PWDATA[7:0]};
            end
            for (int j = 0; j < NCH; j++) begin
                if (j == k || (s.sync[k] && s.sync[j])) begin
                    if (hit && wr_now) begin
                        cwr[j] = 1'b1;
                        cval[j] = full;
                    end
                    if (hit && is_byte && PSEL && PWRITE &&
                        s.phase != PH_IDLE) begin
                        bhold[j] = 1'b1;
                    end
                end
            end
        end
        // Timer events of each channel.
        for (int c = 0; c < NCH; c++) begin
            inc[c] = s.ctl[c][CTL_RUN] && tick[s.ctl[c][CTL_CKS+:2]];
            wrap[c] = inc[c] && (s.ctl[c][CTL_DOWN] ? s.cnt[c] == CNT_RST
                                                    : s.cnt[c] == CNT_MAX);
            gra_wr[c] = wr_now && ch_hit(PADDR, c, OFS_GRA);
            grb_wr[c] = wr_now && ch_hit(PADDR, c, OFS_GRB);
            cap_a[c] = s.ctl[c][CTL_CAPA] && CAPTURE_A[c];
            cap_b[c] = s.ctl[c][CTL_CAPB] && CAPTURE_B[c];
            cmp_a[c] = inc[c] && !s.ctl[c][CTL_CAPA] &&
                       s.cnt[c] == s.gra[c] && !gra_wr[c];
            cmp_b[c] = inc[c] && !s.ctl[c][CTL_CAPB] &&
                       s.cnt[c] == s.grb[c] && !grb_wr[c];
            case (s.ctl[c][CTL_CLR+:2])
                CLR_A: own_clr[c] = cmp_a[c] || cap_a[c];
                CLR_B: own_clr[c] = cmp_b[c] || cap_b[c];
                default: own_clr[c] = 1'b0;
            endcase
        end
        // Synchronous clear follows any synced channel that clears itself.
        for (int c = 0; c < NCH; c++) begin
            clr[c] = own_clr[c] || (s.ctl[c][CTL_CLR+:2] == CLR_SYNC &&
                                    s.sync[c] && |(own_clr & s.sync));
        end
        // Register and flag updates of each channel.
        for (int c = 0; c < NCH; c++) begin
            // Clear beats a write, a write beats the count.
            if (clr[c]) begin
                n.cnt[c] = CNT_RST;
            end else if (cwr[c]) begin
                n.cnt[c] = cval[c];
            end else if (inc[c] && !bhold[c]) begin
                n.cnt[c] = s.ctl[c][CTL_DOWN] ? 16'(s.cnt[c] - 16'h0001)
                                              : 16'(s.cnt[c] + 16'h0001);
            end
            evts = '0;
            evts[FLAG_A] = cmp_a[c] || cap_a[c];
            evts[FLAG_B] = cmp_b[c] || cap_b[c];
            evts[FLAG_WRAP] = wrap[c] && !clr[c];
            ev_all[c*NFLAG+:NFLAG] = evts;
            // Capture takes the old count and wins over any register write.
            if (cap_a[c]) begin
                n.gra[c] = s.cnt[c];
                if (s.ctl[c][CTL_BUFA]) begin
                    n.bra[c] = s.gra[c];
                end
            end else if (cmp_a[c] && s.ctl[c][CTL_BUFA]) begin
                n.gra[c] = s.bra[c];
            end else if (gra_wr[c]) begin
                n.gra[c] = PWDATA[15:0];
            end
            if (wr_now && ch_hit(PADDR, c, OFS_BRA) &&
                !(cap_a[c] && s.ctl[c][CTL_BUFA])) begin
                n.bra[c] = PWDATA[15:0];
            end
            if (cap_b[c]) begin
                n.grb[c] = s.cnt[c];
            end else if (grb_wr[c]) begin
                n.grb[c] = PWDATA[15:0];
            end
            if (wr_now && ch_hit(PADDR, c, OFS_CTL)) begin
                n.ctl[c] = PWDATA[CTL_W-1:0];
            end
            // A flag read as one arms it; a later zero write clears it.
            fclr = '0;
            n.armed[c] = s.armed[c];
            if (commit && ch_hit(PADDR, c, OFS_FLAG)) begin
                if (PWRITE) begin
                    fclr = s.armed[c] & ~PWDATA[NFLAG-1:0];
                    n.armed[c] = '0;
                end else begin
                    n.armed[c] = s.armed[c] | s.flag[c];
                end
            end
            n.flag[c] = (s.flag[c] & ~fclr) | evts;
        end
        // Shared registers; an interrupt event wins over its clear.
        if (wr_now && PADDR == OFS_SYNC) begin
            n.sync = PWDATA[NCH-1:0];
        end
        if (wr_now && PADDR == OFS_FMODE) begin
            n.fmode = PWDATA[1:0];
        end
        if (wr_now && PADDR == OFS_IEN) begin
            n.ien = PWDATA[IW-1:0];
        end
        n.ist = s.ist | ev_all;
        if (wr_now && PADDR == OFS_ICLR) begin
            n.ist = (s.ist & ~PWDATA[IW-1:0]) | ev_all;
        end
        // Read data is latched in the second state, before third state events.
        if (int'(ch) < NCH) begin
            ok = 1'b1;
            case ({PADDR[4:0]})
                OFS_CNT[4:0]: rd = {16'h0000, s.cnt[ch]};
                OFS_CNT_HI[4:0]: rd = {24'h000000, s.cnt[ch][15:8]};
                OFS_CNT_LO[4:0]: rd = {24'h000000, s.cnt[ch][7:0]};
                OFS_GRA[4:0]: rd = {16'h0000, s.gra[ch]};
                OFS_GRB[4:0]: rd = {16'h0000, s.grb[ch]};
                OFS_BRA[4:0]: rd = {16'h0000, s.bra[ch]};
                OFS_CTL[4:0]: rd = 32'(s.ctl[ch]);
                OFS_FLAG[4:0]: rd = 32'(s.flag[ch]);
                default: ok = 1'b0;
            endcase
        end else begin
            ok = 1'b1;
            case (PADDR)
                OFS_SYNC: rd = 32'(s.sync);
                OFS_FMODE: rd = 32'(s.fmode);
                OFS_IST: rd = 32'(s.ist);
                OFS_ICLR: rd = 32'h00000000;
                OFS_IEN: rd = 32'(s.ien);
                default: ok = 1'b0;
            endcase
        end
        if (s.phase == PH_T2 && PSEL) begin
            n.rdata = PWRITE ? 32'h00000000 : rd;
            n.slverr = !ok;
        end
    end

    // State register.
    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            s.phase <= PH_IDLE;
            s.cnt <= {NCH{CNT_RST}};
            s.gra <= {NCH{GR_RST}};
            s.grb <= {NCH{GR_RST}};
            s.bra <= {NCH{GR_RST}};
            s.ctl <= {NCH{CTL_RST}};
            s.flag <= '0;
            s.armed <= '0;
            s.sync <= '0;
            s.fmode <= '0;
            s.ist <= '0;
            s.ien <= '0;
            s.rdata <= '0;
            s.slverr <= 1'b0;
        end else begin
            s <= n;
        end
    end

    // Bus answer in the third state, data and mode straight from flip-flops.
    assign PREADY = acc && (s.phase == PH_T3);
    assign PSLVERR = PREADY && s.slverr;
    assign PRDATA = s.rdata;
    assign COMBINED_MODE = s.fmode;
    assign IRQ = |(s.ist & s.ien);

    // Checks on channel zero and the last channel.
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RESET_N);

    clear_wins_a: assert property (clr[0] && cwr[0] |=> s.cnt[0] == CNT_RST)
        else $error("Counter write was not dropped on clear.");
    word_write_a: assert property (cwr[0] && !clr[0] && inc[0]
        |=> s.cnt[0] == $past(cval[0]))
        else $error("Counter write lost to an increment.");
    byte_hold_a: assert property (bhold[0] && !cwr[0] && !clr[0]
        |=> s.cnt[0] == $past(s.cnt[0]))
        else $error("Counter moved during a byte write.");
    match_inhibit_a: assert property (gra_wr[0] && !cap_a[0]
        |=> !$rose(s.flag[0][FLAG_A]))
        else $error("Compare match raised during a register write.");
    wrap_write_a: assert property (cwr[0] && wrap[0] && !clr[0]
        |=> s.flag[0][FLAG_WRAP] && s.cnt[0] == $past(cval[0]))
        else $error("Wrap flag or written value lost.");
    read_precap_a: assert property (PREADY && !PWRITE && cap_a[0] &&
        PADDR == OFS_GRA |-> PRDATA[15:0] == s.gra[0])
        else $error("Read returned the captured value.");
    cap_clear_a: assert property (cap_a[0] && clr[0]
        |=> s.cnt[0] == CNT_RST && s.gra[0] == $past(s.cnt[0]))
        else $error("Clearing capture lost the old count.");
    match_period_a: assert property (cmp_a[0] &&
        s.ctl[0][CTL_CLR+:2] == CLR_A |=> s.cnt[0] == CNT_RST)
        else $error("Clear on match came at the wrong count.");
    sync_load_a: assert property (s.sync[0] && s.sync[NCH-1] && cwr[0] &&
        !clr[0] && !clr[NCH-1] |=> s.cnt[0] == s.cnt[NCH-1])
        else $error("Synced counters differ after a preset.");
    flag_clear_a: assert property ($fell(s.flag[0][FLAG_A])
        |-> $past(s.armed[0][FLAG_A]))
        else $error("Flag cleared without a prior read as one.");
    three_state_a: assert property (PSEL && !PENABLE && s.phase == PH_IDLE
        ##1 PSEL && PENABLE |-> !PREADY ##1 PREADY)
        else $error("Access did not end in its third state.");
    // Buffer transfer and wrap flag on channel zero.
    buf_capture_a: assert property (cap_a[0] && s.ctl[0][CTL_BUFA]
        |=> s.bra[0] == $past(s.gra[0]))
        else $error("Capture did not move the old value to the buffer.");
    wrap_flag_a: assert property (wrap[0] && !clr[0]
        |=> s.flag[0][FLAG_WRAP])
        else $error("Wrap flag missed a counter wrap.");
    byte_hold_c: cover property (bhold[0] ##1 bhold[0] && cwr[0]);
    wrap_seen_c: cover property (wrap[0] ##1 s.flag[0][FLAG_WRAP]);
    cap_clear_c: cover property (cap_a[0] && clr[0]);
    sync_preset_c: cover property (s.sync[0] && s.sync[NCH-1] && cwr[0]);
    irq_c: cover property (!IRQ ##1 IRQ);
endmodule : tcc_timer
`default_nettype wire

// ### verilog/tcc_pkg.sv
// Constants and types shared by the timer channel contention block.
// How it works
// - A counter clear in the write's third state wins; the written value is dropped.
// - A word counter write in the third state wins over an increment.
// - A byte write in state two or three stores the byte, skips increment.
// - A general register write in the third state suppresses its compare match.
// - A counter write wins over wrap stepping, but the wrap flag still sets.
// - A register read that meets a capture returns the value before capture.
// - A clearing capture with an increment clears; the register gets the old count.
// - A capture in the third state of a register write wins; write dropped.
// - Clear on match happens as the count leaves N, giving N+1 counts.
// - A capture wins over a write to the capture buffer register.
// - A synced byte write loads the addressed counter's full result everywhere.
// - A synced word write loads the same value into every synced counter.
// - Compare match rises in the last equal state, as the count advances.
// - The wrap flag sets on FFFF to 0 upward or 0 to FFFF downward.
// - A status flag clears only after it was read as 1, then written 0.
package tcc_pkg;
    // Channel register offsets, channel base is index times the stride.
    localparam logic [7:0] CH_STRIDE = 8'h20;
    localparam logic [7:0] OFS_CNT = 8'h00;
    localparam logic [7:0] OFS_CNT_HI = 8'h04;
    localparam logic [7:0] OFS_CNT_LO = 8'h08;
    localparam logic [7:0] OFS_GRA = 8'h0C;
    localparam logic [7:0] OFS_GRB = 8'h10;
    localparam logic [7:0] OFS_BRA = 8'h14;
    localparam logic [7:0] OFS_CTL = 8'h18;
    localparam logic [7:0] OFS_FLAG = 8'h1C;
    // Shared register offsets.
    localparam logic [7:0] OFS_SYNC = 8'hE0;
    localparam logic [7:0] OFS_FMODE = 8'hE4;
    localparam logic [7:0] OFS_IST = 8'hE8;
    localparam logic [7:0] OFS_ICLR = 8'hEC;
    localparam logic [7:0] OFS_IEN = 8'hF0;
    // Channel control field positions.
    localparam int CTL_RUN = 0;
    localparam int CTL_DOWN = 1;
    localparam int CTL_CLR = 2;
    localparam int CTL_CAPA = 4;
    localparam int CTL_CAPB = 5;
    localparam int CTL_BUFA = 6;
    localparam int CTL_CKS = 7;
    localparam int CTL_W = 9;
    // Clear source codes.
    localparam logic [1:0] CLR_NONE = 2'h0;
    localparam logic [1:0] CLR_A = 2'h1;
    localparam logic [1:0] CLR_B = 2'h2;
    localparam logic [1:0] CLR_SYNC = 2'h3;
    // Status flag positions.
    localparam int FLAG_A = 0;
    localparam int FLAG_B = 1;
    localparam int FLAG_WRAP = 2;
    localparam int NFLAG = 3;
    // Reset values and counter limits.
    localparam logic [15:0] CNT_RST = 16'h0000;
    localparam logic [15:0] CNT_MAX = 16'hFFFF;
    localparam logic [15:0] GR_RST = 16'hFFFF;
    localparam logic [CTL_W-1:0] CTL_RST = 9'h000;
    localparam int NCH_DEF = 2;
    localparam int NRATE = 4;
    // Bus access states, Gray coded along setup, second and third state.
    typedef enum logic [1:0] {
        PH_IDLE = 2'b00,
        PH_T2 = 2'b01,
        PH_T3 = 2'b11
    } tcc_phase_t;
endpackage : tcc_pkg

// ### verilog/tcc_prescale.sv
// Clock prescaler that makes the count enable pulses.
`timescale 1ns/10ps
`default_nettype none
module tcc_prescale
    import tcc_pkg::*;
#(
    parameter int NR = NRATE
) (
    input wire logic CLOCK,
    input wire logic RESET_N,
    output logic [NR-1:0] TICK
);
    typedef struct packed {
        logic [NR-1:0] div;
    } tccp_state_t;

    tccp_state_t s;
    tccp_state_t n;

    // The divider free runs from reset.
    always_comb begin
        n = s;
        n.div = s.div + 1'b1;
    end

    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    // Rate i pulses once every two to the power i cycles.
    genvar i;
    generate
        for (i = 0; i < NR; i++) begin : g_rate
            if (i == 0) begin : g_full
                assign TICK[i] = 1'b1;
            end else begin : g_div
                assign TICK[i] = &s.div[i-1:0];
            end
        end
    endgenerate
endmodule : tcc_prescale
`default_nettype wire

// ### verification/tcc_cpu_model.sv
// Processor bus master model that drives the timer block's APB port.
`timescale 1ns/10ps
`default_nettype none
module tcc_cpu_model
    import tcc_pkg::*;
(
    input wire logic clock,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    output logic in_t2
);
    localparam logic [7:0] CTL3 = CH_STRIDE * 8'h03 + OFS_CTL;
    localparam logic [7:0] CTL4 = CH_STRIDE * 8'h04 + OFS_CTL;

    // The bus is idle at time zero.
    initial begin
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = 8'h00;
        pwdata = 32'h00000000;
        in_t2 = 1'h0;
    end

    // One transfer: setup state, then access states until the answer.
    task automatic xfer(input logic wr, input logic [7:0] a,
                        input logic [31:0] d, output logic [31:0] rd,
                        output logic err);
        @(posedge clock);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'h1;
        in_t2 <= 1'h1;
        @(posedge clock);
        in_t2 <= 1'h0;
        while (pready !== 1'h1) @(posedge clock);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        // Released lines carry garbage so nothing leans on old values.
        paddr <= ~a;
        pwdata <= ~d;
    endtask : xfer

    // Clears flags: read them first, then write zero to the chosen bits.
    task automatic flag_clear(input logic [7:0] a, input logic [31:0] keep);
        logic [31:0] rd;
        logic err;
        xfer(1'h0, a, 32'h00000000, rd, err);
        xfer(1'h1, a, rd & keep, rd, err);
    endtask : flag_clear

    // Changes the combined mode: stop channels 3 and 4, pass through mode cur[0].
    task automatic set_mode(input logic [1:0] m, input logic [1:0] cur);
        logic [31:0] rd;
        logic err;
        xfer(1'h1, CTL3, 32'h00000000, rd, err);
        xfer(1'h1, CTL4, 32'h00000000, rd, err);
        xfer(1'h1, OFS_FMODE, {31'h0, cur[0]}, rd, err);
        xfer(1'h1, OFS_FMODE, {30'h0, m}, rd, err);
    endtask : set_mode
endmodule : tcc_cpu_model
`default_nettype wire

// ### verification/tcc_timer_tb.sv
// Self-checking testbench for the timer channel contention block.
`timescale 1ns/10ps
`default_nettype none
module tcc_timer_tb
    import tcc_pkg::*;
;
    localparam int NC = 5;
    localparam logic [31:0] ALL = 32'hFFFFFFFF;
    localparam logic [31:0] K_RUN = 32'h1 << CTL_RUN;
    localparam logic [31:0] K_DOWN = 32'h1 << CTL_DOWN;
    localparam logic [31:0] K_CLRA = {30'h0, CLR_A} << CTL_CLR;
    localparam logic [31:0] K_CAPA = 32'h1 << CTL_CAPA;
    localparam logic [31:0] K_BUFA = 32'h1 << CTL_BUFA;
    localparam logic [31:0] K_WRAP = 32'h1 << FLAG_WRAP;
    localparam logic [7:0] CH1 = CH_STRIDE;
    localparam logic [7:0] CH4 = CH_STRIDE * 8'h04;
    logic clock;
    logic reset_n;
    logic psel, penable, pwrite, pready, pslverr, in_t2, irq, cap_arm;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [NC-1:0] cap_a = '0;
    logic [1:0] cmode;
    int mismatches = 0;
    int cmp_count = 0;
    int cyc = 0;

    tcc_timer #(.NCH(NC)) tcc_timer_i (
        .CLOCK(clock), .RESET_N(reset_n), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .CAPTURE_A(cap_a),
        .CAPTURE_B({NC{1'h0}}), .COMBINED_MODE(cmode), .IRQ(irq));
    tcc_cpu_model tcc_cpu_model_i (
        .clock(clock), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .in_t2(in_t2));

    // Free running 40 MHz clock.
    initial begin
        clock = 1'h0;
        forever #12.5 clock = ~clock;
    end

    // A capture pulse, when armed, lands in the third state of an access.
    always @(posedge clock) begin
        cap_a <= in_t2 ? {{(NC-1){1'h0}}, cap_arm} : '0;
    end

    // Cuts a hung run short.
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            mismatches++;
            final_report();
        end
    end

    task automatic final_report();
        if (mismatches == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : final_report

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic er;
        tcc_cpu_model_i.xfer(1'h1, a, d, rd, er);
    endtask : wr

    task automatic rdc(input logic [7:0] a, input logic [31:0] m,
                       input logic [31:0] e);
        logic [31:0] rd;
        logic er;
        tcc_cpu_model_i.xfer(1'h0, a, 32'h0, rd, er);
        chk(rd & m, e);
    endtask : rdc

    // Reset values, then a refused read of an unmapped address.
    task automatic t_reset();
        logic [31:0] rd;
        logic er;
        rdc(OFS_CNT, ALL, {16'h0, CNT_RST});
        rdc(OFS_GRA, ALL, {16'h0, GR_RST});
        rdc(OFS_CTL, ALL, 32'h0);
        tcc_cpu_model_i.xfer(1'h0, 8'hC4, 32'h0, rd, er);
        chk(rd, 32'h0);
        chk({30'h0, er, irq}, 32'h2);
    endtask : t_reset

    // A word write meets the increment that would wrap the counter.
    task automatic t_wrap();
        wr(OFS_CTL, K_RUN);
        wr(OFS_CNT, 32'hFFFC);
        wr(OFS_CNT, 32'h0100);
        rdc(OFS_CNT, ALL, 32'h0102);
        wr(OFS_FLAG, 32'h0);
        rdc(OFS_FLAG, K_WRAP, K_WRAP);
    endtask : t_wrap

    // The wrap event raises, is masked and is cleared.
    task automatic t_irq();
        wr(OFS_IEN, K_WRAP);
        @(negedge clock);
        chk({31'h0, irq}, 32'h1);
        wr(OFS_IEN, 32'h0);
        @(negedge clock);
        chk({31'h0, irq}, 32'h0);
        wr(OFS_IEN, K_WRAP);
        wr(OFS_ICLR, K_WRAP);
        @(negedge clock);
        chk({31'h0, irq}, 32'h0);
        rdc(OFS_IST, K_WRAP, 32'h0);
    endtask : t_irq

    // The flag clears after it has been read as set.
    task automatic t_flag();
        tcc_cpu_model_i.flag_clear(OFS_FLAG, ~K_WRAP);
        rdc(OFS_FLAG, K_WRAP, 32'h0);
    endtask : t_flag

    // Clearing captures against counter and register accesses.
    task automatic t_capture();
        wr(OFS_CTL, 32'h0);
        wr(OFS_CNT, 32'h0);
        wr(OFS_CTL, K_RUN | K_CLRA | K_CAPA);
        cap_arm = 1'h1;
        wr(OFS_CNT, 32'h7777);
        cap_arm = 1'h0;
        rdc(OFS_CNT, ALL, 32'h2);
        rdc(OFS_GRA, ALL, 32'h3);
        cap_arm = 1'h1;
        rdc(OFS_GRA, ALL, 32'h3);
        wr(OFS_GRA, 32'h5555);
        cap_arm = 1'h0;
        rdc(OFS_GRA, ALL, 32'h3);
        wr(OFS_CTL, K_RUN | K_CLRA | K_CAPA | K_BUFA);
        cap_arm = 1'h1;
        wr(OFS_BRA, 32'hAAAA);
        cap_arm = 1'h0;
        rdc(OFS_BRA, ALL, 32'h3);
    endtask : t_capture

    // Clear on compare gives N+1 counts; a register write hides a match.
    task automatic t_period();
        wr(OFS_CTL, 32'h0);
        wr(OFS_CNT, 32'h0);
        wr(OFS_GRA, 32'h5);
        tcc_cpu_model_i.flag_clear(OFS_FLAG, 32'hFFFFFFFE);
        rdc(OFS_FLAG, 32'h1, 32'h0);
        wr(OFS_CTL, K_RUN | K_CLRA);
        for (int i = 0; i < 5; i++) begin
            rdc(OFS_CNT, ALL, 32'((2 + 4 * i) % 6));
        end
        wr(OFS_GRA, 32'h5);
        rdc(OFS_CNT, ALL, 32'h8);
        rdc(OFS_FLAG, 32'h1, 32'h1);
    endtask : t_period

    // A byte write holds off the increment in its second and third states.
    task automatic t_byte();
        wr(OFS_CTL, K_RUN);
        wr(OFS_CNT, 32'h10F0);
        wr(OFS_CNT_HI, 32'hAB);
        rdc(OFS_CNT, ALL, 32'hABF4);
    endtask : t_byte

    // A word write meets the underflow of a down count.
    task automatic t_down();
        wr(OFS_CTL, K_RUN | K_DOWN);
        wr(OFS_CNT, 32'h0003);
        wr(OFS_CNT, 32'h0200);
        rdc(OFS_CNT, ALL, 32'h01FE);
        rdc(OFS_FLAG, K_WRAP, K_WRAP);
    endtask : t_down

    // Writes to synchronized counters reach every synced channel.
    task automatic t_sync();
        wr(OFS_CTL, 32'h0);
        wr(OFS_SYNC, 32'h13);
        wr(OFS_CNT, 32'h1234);
        rdc(CH1 + OFS_CNT, ALL, 32'h1234);
        wr(CH1 + OFS_CNT_HI, 32'hAB);
        rdc(OFS_CNT, ALL, 32'hAB34);
        wr(OFS_CNT_LO, 32'h56);
        rdc(CH1 + OFS_CNT, ALL, 32'hAB56);
        rdc(CH4 + OFS_CNT, ALL, 32'hAB56);
    endtask : t_sync

    // Every combined mode is selected and shows at the mode output.
    task automatic t_mode();
        for (int m = 1; m < 5; m++) begin
            tcc_cpu_model_i.set_mode(2'(m), cmode);
            @(negedge clock);
            chk({30'h0, cmode}, 32'(m % 4));
        end
    endtask : t_mode

    // Main sequence.
    initial begin
        reset_n = 1'h0;
        cap_arm = 1'h0;
        repeat (12) @(posedge clock);
        reset_n <= 1'h1;
        t_reset();
        t_wrap();
        t_irq();
        t_flag();
        t_capture();
        t_period();
        t_byte();
        t_down();
        t_sync();
        t_mode();
        final_report();
    end
endmodule : tcc_timer_tb
`default_nettype wire
